// [logic/tsm_pkg.sv]
// shared constants and types of the smbus slave block
package tsm_pkg;

  // three-level strap encoding
  localparam logic [1:0] TSM_LVL_LOW  = 2'h0;
  localparam logic [1:0] TSM_LVL_OPEN = 2'h1;
  localparam logic [1:0] TSM_LVL_HIGH = 2'h2;

  // slave address table, index = pin_a level * 3 + pin_b level
  localparam logic [8:0][6:0] TSM_ADDR_TABLE = {
    7'h4e, 7'h4d, 7'h4c,
    7'h2b, 7'h2a, 7'h29,
    7'h1a, 7'h19, 7'h18
  };

  // alert response address
  localparam logic [6:0] TSM_ARA_ADDR = 7'h0c;

  // register pointer of the single conversion trigger
  localparam logic [7:0] TSM_PTR_ONE_SHOT = 8'h0f;

  // bits per byte before the acknowledge slot
  localparam logic [3:0] TSM_BYTE_BITS = 4'h8;

  // strap sampling delay after reset release, in cycles
  localparam int unsigned TSM_STRAP_SETTLE = 4;

  // reset values
  localparam logic [7:0] TSM_PTR_RESET = 8'h00;

  // direction bit values
  localparam logic TSM_DIR_WRITE = 1'b0;
  localparam logic TSM_DIR_READ  = 1'b1;

  // slave sequencer, gray coded along the usual path
  typedef enum logic [2:0] {
    TSM_IDLE     = 3'h0,
    TSM_ADDR     = 3'h1,
    TSM_ADDR_ACK = 3'h3,
    TSM_WR_BYTE  = 3'h2,
    TSM_WR_ACK   = 3'h6,
    TSM_RD_BYTE  = 3'h7,
    TSM_RD_ACK   = 3'h5,
    TSM_IGNORE   = 3'h4
  } tsm_state_t;

endpackage : tsm_pkg

// [logic/tsm_strap_if.sv]
// carrier of the captured slave address between strap logic and slave
`timescale 1ns/1ps
`default_nettype none
interface tsm_strap_if;
  logic [6:0] own_addr;
  logic       valid;
  modport src (output own_addr, output valid);
  modport dst (input own_addr, input valid);
endinterface : tsm_strap_if
`default_nettype wire

// [logic/tsm_strap_capture.sv]
// samples the address select straps once after reset and decodes them
`timescale 1ns/1ps
`default_nettype none
module tsm_strap_capture
  import tsm_pkg::*;
#(
  parameter int unsigned SETTLE = TSM_STRAP_SETTLE
)(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // strap pins, three-level coded
  input  wire logic [1:0] addr_select_pin_a_i,
  input  wire logic [1:0] addr_select_pin_b_i,
  // captured address
  tsm_strap_if.src        strap
);

  // settle counter must outlast the three-stage synchroniser
  if (SETTLE < 3 || SETTLE > 15)
  begin : g_chk
    $error("tsm_strap_capture: SETTLE must be 3..15");
  end

  typedef struct packed {
    logic [2:0][1:0] a_sy;
    logic [2:0][1:0] b_sy;
    logic [3:0]      cnt;
    logic [6:0]      addr;
    logic            valid;
  } tsm_strap_st_t;

  tsm_strap_st_t r;
  tsm_strap_st_t next_r;

  // level index, an unused fourth code counts as high
  function automatic logic [3:0] lvl(input logic [1:0] p);
    lvl = (p == 2'h3) ? {2'h0, TSM_LVL_HIGH} : {2'h0, p};
  endfunction : lvl

  // sync straps, capture once when both settled and stable
  always_comb
  begin
    next_r      = r;
    next_r.a_sy = {r.a_sy[1:0], addr_select_pin_a_i};
    next_r.b_sy = {r.b_sy[1:0], addr_select_pin_b_i};
    if (r.cnt != SETTLE[3:0])
      next_r.cnt = r.cnt + 4'h1;
    else if (!r.valid && r.a_sy[1] == r.a_sy[2]
             && r.b_sy[1] == r.b_sy[2])
    begin
      next_r.addr  = TSM_ADDR_TABLE[4'(lvl(r.a_sy[2]) * 4'h3
                                        + lvl(r.b_sy[2]))];
      next_r.valid = 1'b1; // later pin changes ignored
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign strap.own_addr = r.addr;
  assign strap.valid    = r.valid;

endmodule : tsm_strap_capture
`default_nettype wire

// [logic/tsm_smbus_slave.sv]
// smbus slave with pointer registers, alert response and standby control
`timescale 1ns/1ps
`default_nettype none
module tsm_smbus_slave
  import tsm_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // serial bus pins
  input  wire logic       scl_pin_i,
  input  wire logic       serial_data_pin_i,
  output logic            serial_data_pin_o,
  output logic            serial_data_pin_oe_o,
  // address straps
  input  wire logic [1:0] addr_select_pin_a_i,
  input  wire logic [1:0] addr_select_pin_b_i,
  // alarm
  input  wire logic       alarm_cause_i,
  input  wire logic       alarm_mask_bit_i,
  output logic            alarm_pin_n_o,
  output logic            alarm_pin_n_oe_o,
  // standby and conversion control
  input  wire logic       sleep_pin_n_i,
  input  wire logic       cfg_standby_bit_i,
  input  wire logic       conv_busy_i,
  input  wire logic       conv_done_i,
  output logic            adc_run_o,
  output logic            conv_discard_o,
  output logic            one_shot_o,
  output logic            standby_o,
  // register bank side
  input  wire logic [7:0] reg_rdata_i,
  output logic [7:0]      reg_ptr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);

  typedef struct packed {
    logic [2:0] scl_sy;
    logic       scl;
    logic [2:0] sda_sy;
    logic       sda;
    logic [2:0] slp_sy;
    logic       slp_n;
    tsm_state_t fsm;
    logic [3:0] bits;
    logic [1:0] nbyte;
    logic [7:0] sh;
    logic       rw;
    logic       ara;
    logic       drive;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       alarm;
    logic       oneshot;
    logic       osp;
    logic       run;
    logic       disc;
    logic       sleep_pin_n;
  } tsm_slave_st_t;

  tsm_slave_st_t r;
  tsm_slave_st_t next_r;
  tsm_strap_if   strap ();

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic alarm_low;
  logic sleep_req;

  // strap capture
  tsm_strap_capture u_strap (
    .mclk_i              (mclk_i),
    .rst_b_i             (rst_b_i),
    .addr_select_pin_a_i (addr_select_pin_a_i),
    .addr_select_pin_b_i (addr_select_pin_b_i),
    .strap               (strap)
  );

  // filtered level: follows stage two once stages two and three agree
  function automatic logic filt(input logic [2:0] sy, input logic cur);
    filt = (sy[1] == sy[2]) ? sy[2] : cur;
  endfunction : filt

  // sequencer, alarm latch and standby control
  always_comb
  begin
    next_r        = r;
    // three-stage synchronisers on the pins
    next_r.scl_sy = {r.scl_sy[1:0], scl_pin_i};
    next_r.sda_sy = {r.sda_sy[1:0], serial_data_pin_i};
    next_r.slp_sy = {r.slp_sy[1:0], sleep_pin_n_i};
    // levels move once stages two and three agree
    next_r.scl    = filt(r.scl_sy, r.scl);
    next_r.sda    = filt(r.sda_sy, r.sda);
    next_r.slp_n  = filt(r.slp_sy, r.slp_n);
    // one-cycle strobes idle low
    next_r.wr     = 1'b0;
    next_r.rd     = 1'b0;
    next_r.osp    = 1'b0;
    // edges and bus conditions from filtered lines
    rise  = next_r.scl & ~r.scl;
    fall  = ~next_r.scl & r.scl;
    start = r.scl & next_r.scl & r.sda & ~next_r.sda;
    stop  = r.scl & next_r.scl & ~r.sda & next_r.sda;
    alarm_low = r.alarm & ~alarm_mask_bit_i;
    sleep_req = ~next_r.slp_n | cfg_standby_bit_i;

    // one-shot ends on completion, when standby pin takes over or when the standby bit clears
    if (conv_done_i | ~next_r.slp_n | ~cfg_standby_bit_i)
      next_r.oneshot = 1'b0;

    if (stop)
    begin
      next_r.fsm   = TSM_IDLE;
      next_r.drive = 1'b0;
    end
    else if (start)
    begin
      // any start, repeated too, opens a fresh address phase
      next_r.fsm   = TSM_ADDR;
      next_r.bits  = 4'h0;
      next_r.nbyte = 2'h0;
      next_r.ara   = 1'b0;
      next_r.drive = 1'b0;
    end
    else
    begin
      case (r.fsm)
        TSM_IDLE:
          next_r.drive = 1'b0;
        TSM_ADDR:
          if (rise)
          begin
            next_r.sh   = {r.sh[6:0], next_r.sda}; // msb first
            next_r.bits = r.bits + 4'h1;
          end
          else if (fall && r.bits == TSM_BYTE_BITS)
          begin
            next_r.rw = r.sh[0];
            if (strap.valid && r.sh[7:1] == strap.own_addr)
            begin
              next_r.drive = 1'b1; // ack low in ninth slot
              next_r.fsm   = TSM_ADDR_ACK;
            end
            else if (r.sh[7:1] == TSM_ARA_ADDR && strap.valid
                     && r.sh[0] == TSM_DIR_READ && alarm_low)
            begin
              next_r.ara   = 1'b1;
              next_r.drive = 1'b1;
              next_r.fsm   = TSM_ADDR_ACK;
            end
            else
              next_r.fsm = TSM_IGNORE;
          end
        TSM_ADDR_ACK:
          if (fall)
          begin
            next_r.bits = 4'h0;
            if (r.rw == TSM_DIR_READ)
            begin
              // read: load byte and present its msb
              if (r.ara)
                next_r.sh = {strap.own_addr, 1'b0};
              else
              begin
                next_r.sh = reg_rdata_i;
                next_r.rd = 1'b1;
              end
              next_r.drive = ~next_r.sh[7];
              next_r.fsm   = TSM_RD_BYTE;
            end
            else
            begin
              next_r.drive = 1'b0;
              next_r.fsm   = TSM_WR_BYTE;
            end
          end
        TSM_WR_BYTE:
          if (rise)
          begin
            next_r.sh   = {r.sh[6:0], next_r.sda};
            next_r.bits = r.bits + 4'h1;
          end
          else if (fall && r.bits == TSM_BYTE_BITS)
          begin
            if (r.nbyte == 2'h0)
            begin
              next_r.ptr   = r.sh;
              next_r.nbyte = 2'h1;
              next_r.drive = 1'b1;
              next_r.fsm   = TSM_WR_ACK;
              if (r.sh == TSM_PTR_ONE_SHOT && cfg_standby_bit_i
                  && next_r.slp_n && !r.oneshot)
              begin
                next_r.oneshot = 1'b1;
                next_r.osp     = 1'b1;
              end
            end
            else if (r.nbyte == 2'h1)
            begin
              // trigger location keeps no data
              if (r.ptr != TSM_PTR_ONE_SHOT)
              begin
                next_r.wdata = r.sh;
                next_r.wr    = 1'b1;
              end
              next_r.nbyte = 2'h2;
              next_r.drive = 1'b1;
              next_r.fsm   = TSM_WR_ACK;
            end
            else
              next_r.fsm = TSM_IGNORE; // third byte refused
          end
        TSM_WR_ACK:
          if (fall)
          begin
            next_r.drive = 1'b0;
            next_r.bits  = 4'h0;
            next_r.fsm   = TSM_WR_BYTE;
          end
        TSM_RD_BYTE:
          if (rise)
          begin
            next_r.bits = r.bits + 4'h1;
            // released a one but line is low: lost arbitration
            if (r.ara && !r.drive && !next_r.sda)
              next_r.fsm = TSM_IGNORE;
          end
          else if (fall)
          begin
            if (r.bits == TSM_BYTE_BITS)
            begin
              next_r.drive = 1'b0;
              next_r.fsm   = TSM_RD_ACK;
            end
            else
            begin
              next_r.sh    = {r.sh[6:0], 1'b0};
              next_r.drive = ~r.sh[6]; // change while low
            end
          end
        TSM_RD_ACK:
          if (rise)
          begin
            // alert serviced: drop latch if cause gone
            if (r.ara && !alarm_cause_i)
              next_r.alarm = 1'b0;
            next_r.fsm = TSM_IGNORE; // single byte reads
          end
        TSM_IGNORE:
          next_r.drive = 1'b0;
        default:
        begin
          next_r.fsm   = TSM_IDLE;
          next_r.drive = 1'b0;
        end
      endcase
    end

    // lost arbitration or ignore always releases the line
    if (next_r.fsm == TSM_IGNORE || next_r.fsm == TSM_IDLE)
      next_r.drive = 1'b0;

    // alarm latch, a new cause wins over service
    if (alarm_cause_i)
      next_r.alarm = 1'b1;

    // standby and ADC run control
    next_r.sleep_pin_n = sleep_req;
    next_r.run  = ~sleep_req | next_r.oneshot;
    next_r.disc = r.run & ~next_r.run & conv_busy_i;
  end

  // state register, bus lines and sleep pin idle high
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      r        <= '0;
      r.scl_sy <= 3'h7;
      r.scl    <= 1'b1;
      r.sda_sy <= 3'h7;
      r.sda    <= 1'b1;
      r.slp_sy <= 3'h7;
      r.slp_n  <= 1'b1;
      r.ptr    <= TSM_PTR_RESET;
      r.sleep_pin_n   <= 1'b0;
    end
    else
      r <= next_r;
  end

  // open-drain pins only ever pull low
  assign serial_data_pin_o    = 1'b0;
  assign serial_data_pin_oe_o = r.drive;
  assign alarm_pin_n_o        = 1'b0;
  assign alarm_pin_n_oe_o     = alarm_low; // wire-and

  // register bank and conversion outputs
  assign reg_ptr_o      = r.ptr;
  assign reg_wdata_o    = r.wdata;
  assign reg_wr_o       = r.wr;
  assign reg_rd_o       = r.rd;
  assign adc_run_o      = r.run;
  assign conv_discard_o = r.disc;
  assign one_shot_o     = r.osp;
  assign standby_o      = r.sleep_pin_n;

endmodule : tsm_smbus_slave
`default_nettype wire

// [test/tsm_host_model.sv]
// smbus host model: drives the bus clock, open-drain master of the data line
`timescale 1ns/1ps
`default_nettype none
module tsm_host_model (
  // clock and data wire level
  input  wire logic mclk_i,
  input  wire logic sda_i,
  // lines pulled by the host
  output var logic  scl_o,
  output var logic  sda_oe_o
);
  // bus idle: clock stands high, data released
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // wait n cycles, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask : tick

  // start, also usable as a repeated start
  task automatic start();
    tick(2);
    sda_oe_o = 1'b0;
    scl_o    = 1'b1;
    tick(4);
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask : start

  // one pulse: drive in low phase, sample late in high phase
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_oe_o = ~b;
    tick(3);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    tick(1);
    scl_o = 1'b0;
  endtask : bit_x

  // eight bits msb first, slot left high (ack read or not-ack)
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(1'b1, ack_n);
  endtask : byte_x

  // stop: data low in low phase, rises while clock high
  task automatic stop();
    tick(2);
    sda_oe_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(3);
    sda_oe_o = 1'b0;
    tick(4);
  endtask : stop
endmodule : tsm_host_model
`default_nettype wire

// [test/tsm_smbus_slave_props.sv]
// port assertions of the smbus slave
`timescale 1ns/1ps
`default_nettype none
module tsm_smbus_slave_props
  import tsm_pkg::*;
(
  // clock, reset and inputs
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       scl_pin_i,
  input wire logic       alarm_cause_i,
  input wire logic       alarm_mask_bit_i,
  input wire logic       sleep_pin_n_i,
  input wire logic       cfg_standby_bit_i,
  input wire logic       conv_busy_i,
  input wire logic       conv_done_i,
  // outputs
  input wire logic       serial_data_pin_oe_o,
  input wire logic       alarm_pin_n_oe_o,
  input wire logic       adc_run_o,
  input wire logic       conv_discard_o,
  input wire logic       one_shot_o,
  input wire logic       standby_o,
  input wire logic [7:0] reg_ptr_o,
  input wire logic       reg_wr_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sda_edge_a:
    assert property ($rose(serial_data_pin_oe_o) |-> !$past(scl_pin_i, 2))
    else $error("data drive began in high phase");
  ptr_edge_a:
    assert property ($changed(reg_ptr_o) |-> !$past(scl_pin_i, 2))
    else $error("pointer moved in high phase");
  wr_pulse_a:
    assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe too long");
  trig_kept_a:
    assert property (reg_wr_o |-> reg_ptr_o != TSM_PTR_ONE_SHOT)
    else $error("trigger data stored");
  mask_out_a:
    assert property (alarm_mask_bit_i |-> !alarm_pin_n_oe_o)
    else $error("masked alarm driven");
  alarm_set_a:
    assert property (alarm_cause_i && !alarm_mask_bit_i ##1
                     !alarm_mask_bit_i |-> alarm_pin_n_oe_o)
    else $error("alarm not driven");
  sw_standby_a:
    assert property (cfg_standby_bit_i [*3] |-> standby_o)
    else $error("standby bit ignored");
  pin_block_a:
    assert property (!sleep_pin_n_i [*6] |-> !adc_run_o && standby_o)
    else $error("conversion under standby pin");
  shot_run_a:
    assert property (one_shot_o |-> ##[0:1] adc_run_o)
    else $error("one-shot without run");
  done_stop_a:
    assert property (standby_o && conv_done_i |=> ##[0:1] !adc_run_o)
    else $error("no return to standby");
  discard_a:
    assert property (conv_discard_o |-> $fell(adc_run_o) && $past(conv_busy_i))
    else $error("bad discard pulse");
endmodule : tsm_smbus_slave_props
bind tsm_smbus_slave tsm_smbus_slave_props chk_u (.*);
`default_nettype wire

// [test/tb_smbus_slave_alert_standby.sv]
// self-checking bench of the smbus slave with host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH %0t compare %0d", $time, n_tests); end end
module tb_smbus_slave_alert_standby;
  logic       mclk_i, rst_b_i, cause, mask, sleep_n, cfg, done, busy;
  logic [1:0] pa, pb;
  logic [7:0] salt    = 8'h00;
  logic [31:0] rs     = 32'h0000_9d6b;
  logic       scl, host_oe, dut_oe, sda, alarm_oe, run, shot, sleep_pin_n, wr;
  logic       disc, rd, od_sda, od_alarm;
  logic [7:0] ptr, wdata, rdata, p, r;
  logic [6:0] own;
  logic       ak [4];
  logic [15:0] exp_wr [$];
  logic [6:0] tab [9] = '{7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b,
                          7'h4c, 7'h4d, 7'h4e};
  int         num_errors = 0;
  int         n_tests    = 0;
  int         n_shot     = 0;
  int         n_rd       = 0;
  int         n_disc     = 0;

  // clock, pulled-up data wire, register bank stand-in
  always #25 mclk_i = ~mclk_i;
  assign sda   = ~(host_oe | dut_oe);
  assign rdata = ptr ^ salt;

  tsm_host_model host_u (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
                         .sda_oe_o(host_oe));
  tsm_smbus_slave dut_u (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_pin_i(scl),
    .serial_data_pin_i(sda), .serial_data_pin_o(od_sda),
    .serial_data_pin_oe_o(dut_oe), .addr_select_pin_a_i(pa),
    .addr_select_pin_b_i(pb), .alarm_cause_i(cause),
    .alarm_mask_bit_i(mask), .alarm_pin_n_o(od_alarm),
    .alarm_pin_n_oe_o(alarm_oe),
    .sleep_pin_n_i(sleep_n), .cfg_standby_bit_i(cfg), .conv_busy_i(busy),
    .conv_done_i(done), .adc_run_o(run), .conv_discard_o(disc),
    .one_shot_o(shot), .standby_o(sleep_pin_n), .reg_rdata_i(rdata),
    .reg_ptr_o(ptr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

  // register writes against the expected queue, one-shots counted
  always @(posedge mclk_i)
  begin
    if (wr === 1'b1)
      `CHK({ptr, wdata}, exp_wr.size() ? exp_wr.pop_front() : 'x)
    if (shot === 1'b1)
      n_shot++;
    if (rd === 1'b1)
      n_rd++;
    if (disc === 1'b1)
      n_disc++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic reset_dut();
    rst_b_i = 1'b0;
    host_u.tick(2);
    rst_b_i = 1'b1;
    host_u.tick(10);
  endtask : reset_dut

  // one transfer: address byte then n bytes (read byte sends b0 bits)
  task automatic op(input logic [6:0] a, input logic d, input int n,
                    input logic [7:0] b0, input logic [7:0] b1);
    logic [7:0] tx [3];
    tx = '{b0, b1, 8'h5a};
    host_u.start();
    host_u.byte_x({a, d}, r, ak[0]);
    for (int i = 0; i < n; i++) host_u.byte_x(tx[i], r, ak[i + 1]);
    host_u.stop();
  endtask : op

  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // some 4100 cycles expected; cut a hang far beyond that
  initial
  begin
    #3_000_000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    // quiet inputs, sleep pin high
    mclk_i  = 1'b0;
    rst_b_i = 1'b0;
    {cause, mask, cfg, done, busy} = 5'h00;
    sleep_n = 1'b1;
    // every strap pair, pin a strap moved after capture
    for (int i = 0; i < 9; i++)
    begin
      pa = 2'(i / 3);
      pb = 2'(i % 3);
      reset_dut();
      pa = ~pa;
      own = tab[i];
      rs = xs(rs);
      p = rs[7:0] | 8'h10;
      op(own, 1'b0, 1, p, 8'h00);
      `CHK(ak[0], 1'b0)
      `CHK(ptr, p)
    end
    op(own ^ 7'h01, 1'b0, 1, 8'h33, 8'h00);
    `CHK({ak[0], ptr}, {1'b1, p})
    // two-byte writes with a refused third byte, then reads
    repeat (3)
    begin
      rs = xs(rs);
      p = rs[7:0] | 8'h10;
      exp_wr.push_back({p, rs[15:8]});
      op(own, 1'b0, 3, p, rs[15:8]);
      `CHK({ak[0], ak[1], ak[2], ak[3]}, 4'b0001)
      salt = rs[23:16];
      op(own, 1'b1, 1, 8'hff, 8'h00);
      `CHK(r, p ^ salt)
    end
    `CHK(n_rd, 3)
    // alarm masked, then shown, lost arbitration, won reply
    cause = 1'b1;
    mask = 1'b1;
    host_u.tick(4);
    `CHK(alarm_oe, 1'b0)
    op(7'h0c, 1'b1, 1, 8'hff, 8'h00);
    `CHK(ak[0], 1'b1)
    mask = 1'b0;
    host_u.tick(4);
    `CHK(alarm_oe, 1'b1)
    op(7'h0c, 1'b1, 1, 8'h20, 8'h00);
    cause = 1'b0;
    host_u.tick(4);
    `CHK({r, alarm_oe}, {8'h20, 1'b1})
    op(7'h0c, 1'b1, 1, 8'hff, 8'h00);
    `CHK({r, alarm_oe}, {own, 2'b00})
    // software standby, one-shot via trigger pointer, pin blocks it
    busy = 1'b1; // conversion under way when standby hits
    cfg = 1'b1;
    host_u.tick(6);
    `CHK({sleep_pin_n, run}, 2'b10)
    `CHK(n_disc, 1)
    op(own, 1'b0, 2, 8'h0f, 8'ha5);
    `CHK({ak[0], ak[1], run, n_shot}, {3'b001, 32'd1})
    busy = 1'b0; // finished conversion keeps its result
    done = 1'b1;
    host_u.tick(1);
    done = 1'b0;
    host_u.tick(2);
    `CHK({sleep_pin_n, run}, 2'b10)
    sleep_n = 1'b0;
    host_u.tick(6);
    op(own, 1'b0, 1, 8'h0f, 8'h00);
    `CHK({ak[0], run, n_shot}, {2'b00, 32'd1})
    `CHK(exp_wr.size(), 0)
    `CHK(n_rd, 3)
    `CHK({n_disc, od_sda, od_alarm}, {32'd1, 2'b00})
    wrap_up();
  end
endmodule : tb_smbus_slave_alert_standby
`default_nettype wire
